/* rtl/gpc_apb_if.sv */
`timescale 1ns/1ns
// apb slave handshake, one wait-free access phase
module gpc_apb_if
    import gpc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic psel,
    input  wire logic penable,
    output logic      pready,
    output logic      wr_stb,
    output logic      rd_stb
);
    gpc_apb_e state;
    gpc_apb_e next_state;

    // next state
    always_comb begin
        case (state)
            ST_IDLE:   next_state = (psel && !penable) ? ST_ACCESS : ST_IDLE;
            ST_ACCESS: next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign pready = 1'b1;
    // write strobe only in the access cycle that follows a setup
    assign wr_stb = psel && penable && (state == ST_ACCESS);
    assign rd_stb = psel && !penable;
endmodule

/* rtl/gpc_pad_ctrl.sv */
`timescale 1ns/1ns
// per-pin decode of one configuration word into pad controls
module gpc_pad_ctrl
    import gpc_pkg::*;
(
    input  wire logic [31:0] cfg,
    input  wire logic        pin_level,
    output logic             pad_oe_n,
    output logic             rx_enable,
    output logic             pull_down_en,
    output logic             pull_up_en,
    output logic             low_drive_en,
    output logic             high_drive_en,
    output logic             low_strong,
    output logic             high_strong,
    output logic             detect
);
    logic [2:0] drv;
    logic [1:0] sense;
    assign drv   = cfg[DRV_HI:DRV_LO];
    assign sense = cfg[SENSE_HI:SENSE_LO];

    // direction and input buffer
    assign pad_oe_n  = ~cfg[OE_BIT];
    assign rx_enable = ~cfg[RXDIS_BIT];

    // pull resistor decode, value 2 treated as none
    assign pull_down_en = (cfg[PULL_HI:PULL_LO] == PULL_DOWN);
    assign pull_up_en   = (cfg[PULL_HI:PULL_LO] == PULL_UP);

    // drive strength and disconnect decode
    always_comb begin
        low_drive_en  = 1'b1;
        high_drive_en = 1'b1;
        low_strong    = 1'b0;
        high_strong   = 1'b0;
        case (drv)
            std_low_std_high: begin
            end
            strong_low_std_high: begin
                low_strong = 1'b1;
            end
            std_low_strong_high: begin
                high_strong = 1'b1;
            end
            strong_low_strong_high: begin
                low_strong  = 1'b1;
                high_strong = 1'b1;
            end
            float_low_std_high: begin
                low_drive_en = 1'b0;
            end
            float_low_strong_high: begin
                low_drive_en = 1'b0;
                high_strong  = 1'b1;
            end
            std_low_float_high: begin
                high_drive_en = 1'b0;
            end
            strong_low_float_high: begin
                high_drive_en = 1'b0;
                low_strong    = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // level sense toward port detect logic
    always_comb begin
        case (sense)
            SENSE_HIGH: detect = pin_level;
            SENSE_LOW:  detect = ~pin_level;
            default:    detect = 1'b0;
        endcase
    end
endmodule

/* rtl/gpc_pin_config.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - bit 0 of each config word selects input (0) or output (1).
// - bit 0 shares storage with the pin's bit of the direction reg.
// - bit 1 low connects the input buffer, high disconnects it.
// - pull field 0 none, 1 pull-down, 3 pull-up.
// - drive 0 standard both, 1 strong low with standard high.
// - drive 2 standard low strong high, 3 strong both levels.
// - drive 4 and 5 float the low side, high standard or strong.
// - drive 6 and 7 float the high side, low standard or strong.
// - sense field 0 off, 2 senses high, 3 senses low.
// - fields sit at bits 0, 1, 3:2, 10:8 and 17:16, others unused.
// - one identical register per pin from 0x730 to 0x73C.
// - each config register resets to 0x00000002.
module gpc_pin_config
    import gpc_pkg::*;
#(
    parameter int N = gpc_pkg::NUM_PINS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] pad_oe_n,
    output logic      [N-1:0] rx_enable,
    output logic      [N-1:0] pull_down_en,
    output logic      [N-1:0] pull_up_en,
    output logic      [N-1:0] low_drive_en,
    output logic      [N-1:0] high_drive_en,
    output logic      [N-1:0] low_strong,
    output logic      [N-1:0] high_strong,
    output logic      [N-1:0] detect,
    output logic             irq
);
    logic [31:0]  cfg [N];
    logic [31:0]  next_cfg [N];
    logic [N-1:0] evt_status;
    logic [N-1:0] next_evt_status;
    logic [N-1:0] evt_mask;
    logic [N-1:0] next_evt_mask;
    logic [N-1:0] detect_q;
    logic [N-1:0] cfg_hit;
    logic [N-1:0] dir_bits;
    logic [N-1:0] rise;
    logic         wr_stb;
    logic         rd_stb;
    logic         hit_dir;
    logic         hit_stat;
    logic         hit_mask;
    logic         hit_lvl;
    logic         mapped;
    logic [31:0]  next_prdata;

    // bus handshake
    gpc_apb_if u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pready  (pready),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb)
    );

    // address decode
    assign hit_dir  = (paddr == DIR_OFS);
    assign hit_stat = (paddr == EVT_STATUS_OFS);
    assign hit_mask = (paddr == EVT_MASK_OFS);
    assign hit_lvl  = (paddr == PIN_LEVEL_OFS);
    assign mapped   = (|cfg_hit) | hit_dir | hit_stat | hit_mask | hit_lvl;
    assign pslverr  = psel && penable && !mapped;

    // per-pin decode, config storage and events
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            // consecutive word offsets from the first config register
            assign cfg_hit[g] = (paddr == IO12_CONFIG_OFS
                                 + 12'(4 * g));
            assign dir_bits[g] = cfg[g][OE_BIT];
            assign rise[g] = detect[g] & ~detect_q[g];

            // next config value, direction alias shares bit 0
            always_comb begin
                next_cfg[g] = cfg[g];
                if (wr_stb && pwrite && cfg_hit[g]) begin
                    next_cfg[g] = pwdata & CFG_WMASK;
                end else if (wr_stb && pwrite && hit_dir) begin
                    next_cfg[g][OE_BIT] = pwdata[g];
                end
            end

            // config register
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg[g] <= CFG_RESET;
                end else begin
                    cfg[g] <= next_cfg[g];
                end
            end

            gpc_pad_ctrl u_pad (
                .cfg           (cfg[g]),
                .pin_level     (pin_in[g]),
                .pad_oe_n      (pad_oe_n[g]),
                .rx_enable     (rx_enable[g]),
                .pull_down_en  (pull_down_en[g]),
                .pull_up_en    (pull_up_en[g]),
                .low_drive_en  (low_drive_en[g]),
                .high_drive_en (high_drive_en[g]),
                .low_strong    (low_strong[g]),
                .high_strong   (high_strong[g]),
                .detect        (detect[g])
            );
        end
    endgenerate

    // sticky events, set wins over write-one-to-clear
    always_comb begin
        next_evt_status = evt_status;
        next_evt_mask   = evt_mask;
        if (wr_stb && pwrite && hit_stat) begin
            next_evt_status = evt_status & ~pwdata[N-1:0];
        end
        if (wr_stb && pwrite && hit_mask) begin
            next_evt_mask = pwdata[N-1:0];
        end
        next_evt_status = next_evt_status | rise;
    end

    // event registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= '0;
            evt_mask   <= '0;
            detect_q   <= '0;
        end else begin
            evt_status <= next_evt_status;
            evt_mask   <= next_evt_mask;
            detect_q   <= detect;
        end
    end

    assign irq = |(evt_status & evt_mask);

    // read data mux
    always_comb begin
        next_prdata = '0;
        for (int i = 0; i < N; i++) begin
            if (cfg_hit[i]) begin
                next_prdata = cfg[i];
            end
        end
        if (hit_dir) begin
            next_prdata[N-1:0] = dir_bits;
        end
        if (hit_stat) begin
            next_prdata[N-1:0] = evt_status;
        end
        if (hit_mask) begin
            next_prdata[N-1:0] = evt_mask;
        end
        if (hit_lvl) begin
            next_prdata[N-1:0] = pin_in;
        end
        if (!(rd_stb && !pwrite)) begin
            next_prdata = prdata;
        end
    end

    // read data register, loaded in setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else begin
            prdata <= next_prdata;
        end
    end

    // write to the first config register is stored, masked, in the next cycle
    a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_stb && pwrite && cfg_hit[0]) |=>
        cfg[0] == ($past(pwdata) & CFG_WMASK))
        else $error("config write not stored");

    // direction alias writes bit 0 of each config
    a_dir_alias: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_stb && pwrite && hit_dir) |=>
        dir_bits == $past(pwdata[N-1:0]))
        else $error("direction alias mismatch");

    // output enable follows bit 0
    a_oe_dir: assert property (@(posedge pclk) disable iff (!presetn)
        pad_oe_n[1] == !cfg[1][OE_BIT])
        else $error("output enable wrong");

    // input buffer follows bit 1
    a_rx_buf: assert property (@(posedge pclk) disable iff (!presetn)
        rx_enable[2] != cfg[2][RXDIS_BIT])
        else $error("input buffer wrong");

    // pull-up only for code 3
    a_pull_up: assert property (@(posedge pclk) disable iff (!presetn)
        pull_up_en[0] == (cfg[0][3:2] == 2'h3) &&
        !(pull_up_en[0] && pull_down_en[0]))
        else $error("pull decode wrong");

    // strong both for code 3
    a_drv_strong: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg[1][10:8] == 3'h3) |-> (low_strong[1] && high_strong[1]
        && low_drive_en[1] && high_drive_en[1]))
        else $error("strong drive wrong");

    // wired-or codes float low side
    a_wired_or: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg[1][10:9] == 2'h2) |-> (!low_drive_en[1] && high_drive_en[1]
        && high_strong[1] == cfg[1][8]))
        else $error("wired-or drive wrong");

    // wired-and codes float high side
    a_wired_and: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg[1][10:9] == 2'h3) |-> (!high_drive_en[1] && low_drive_en[1]
        && low_strong[1] == cfg[1][8]))
        else $error("wired-and drive wrong");

    // detect follows sense setting and pin
    a_detect: assert property (@(posedge pclk) disable iff (!presetn)
        detect[3] == ((cfg[3][17:16] == 2'h2 && pin_in[3]) ||
        (cfg[3][17:16] == 2'h3 && !pin_in[3])))
        else $error("detect decode wrong");

    // detect rise sets sticky status next cycle
    a_evt_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (detect[0] && !detect_q[0]) |=> evt_status[0])
        else $error("event not latched");

    // reset value of configs
    a_reset_val: assert property (@(posedge pclk)
        $rose(presetn) |-> cfg[2] == CFG_RESET || $past(wr_stb))
        else $error("reset value wrong");

    // standard drive on both levels for code 0
    a_drv_std: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[1][10:8] == 3'h0) |-> (low_drive_en[1] && high_drive_en[1]
        && !low_strong[1] && !high_strong[1]))
        else $error("standard drive wrong");

    // strong low side only for code 1
    a_drv_lo_strong: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[1][10:8] == 3'h1) |-> (low_drive_en[1] && high_drive_en[1]
        && low_strong[1] && !high_strong[1]))
        else $error("strong low drive wrong");

    // strong high side only for code 2
    a_drv_hi_strong: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[1][10:8] == 3'h2) |-> (low_drive_en[1] && high_drive_en[1]
        && !low_strong[1] && high_strong[1]))
        else $error("strong high drive wrong");

    // pull-down only for code 1, no pull-up below code 3
    a_pull_down: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[2][3:2] != 2'h3) |-> (!pull_up_en[2]
        && pull_down_en[2] == (cfg[2][3:2] == 2'h1)))
        else $error("pull-down decode wrong");

    // read setup loads the addressed config word
    a_rd_cfg: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_stb && !pwrite && cfg_hit[1]) |=> prdata == $past(cfg[1]))
        else $error("config read data wrong");

    // write-one clears a status bit when no new event
    a_evt_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_stb && pwrite && hit_stat && pwdata[0] && !rise[0])
        |=> !evt_status[0])
        else $error("status clear failed");

    // unmasked event raises the interrupt next cycle
    a_irq_raise: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rise[0] && evt_mask[0] && !(wr_stb && pwrite && hit_mask))
        |=> irq)
        else $error("interrupt not raised");

    // unmapped write leaves the registers alone
    a_unmapped_wr: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_stb && pwrite && !mapped) |=> (cfg[3] == $past(cfg[3])
        && evt_mask == $past(evt_mask)))
        else $error("unmapped write changed state");

    // sense codes 0 and 1 keep detect low
    a_sense_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[1][17] == 1'b0) |-> !detect[1])
        else $error("detect while sense off");
endmodule

/* rtl/gpc_pkg.sv */
package gpc_pkg;
    // register map, byte addresses
    localparam logic [11:0] IO12_CONFIG_OFS = 12'h730;
    localparam logic [11:0] IO13_CONFIG_OFS = 12'h734;
    localparam logic [11:0] IO14_CONFIG_OFS = 12'h738;
    localparam logic [11:0] IO15_CONFIG_OFS = 12'h73C;
    localparam logic [11:0] DIR_OFS         = 12'h750;
    localparam logic [11:0] EVT_STATUS_OFS  = 12'h754;
    localparam logic [11:0] EVT_MASK_OFS    = 12'h758;
    localparam logic [11:0] PIN_LEVEL_OFS   = 12'h75C;
    localparam int          NUM_PINS        = 4;
    localparam int          FIRST_PIN       = 12;
    // field positions
    localparam int OE_BIT     = 0;
    localparam int RXDIS_BIT  = 1;
    localparam int PULL_LO    = 2;
    localparam int PULL_HI    = 3;
    localparam int DRV_LO     = 8;
    localparam int DRV_HI     = 10;
    localparam int SENSE_LO   = 16;
    localparam int SENSE_HI   = 17;
    localparam logic [31:0] CFG_WMASK = 32'h0003070F;
    localparam logic [31:0] CFG_RESET = 32'h00000002;
    // pull encodings
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h3;
    // sense encodings
    localparam logic [1:0] SENSE_OFF  = 2'h0;
    localparam logic [1:0] SENSE_HIGH = 2'h2;
    localparam logic [1:0] SENSE_LOW  = 2'h3;
    // drive encodings
    typedef enum logic [2:0] {
        std_low_std_high       = 3'h0,
        strong_low_std_high    = 3'h1,
        std_low_strong_high    = 3'h2,
        strong_low_strong_high = 3'h3,
        float_low_std_high     = 3'h4,
        float_low_strong_high  = 3'h5,
        std_low_float_high     = 3'h6,
        strong_low_float_high  = 3'h7
    } gpc_drive_e;
    // apb slave states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } gpc_apb_e;
endpackage

/* testbench/gpc_pin_model.sv */
`timescale 1ns/1ns
// far side of the pads: an external source per pin, or the pulls, or float
module gpc_pin_model (
    input  wire logic       clk,
    input  wire logic [3:0] ext_en,
    input  wire logic [3:0] ext_val,
    input  wire logic [3:0] pull_up_en,
    input  wire logic [3:0] pull_down_en,
    output logic      [3:0] level
);
    logic [3:0] flt = 4'h0;

    // a pin nobody holds wanders, so a stale level never looks valid
    always @(posedge clk) begin
        flt <= ~flt;
    end

    // external source wins, then the pull resistor, then the float pattern
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (ext_en[i])
                level[i] = ext_val[i];
            else if (pull_up_en[i])
                level[i] = 1'b1;
            else if (pull_down_en[i])
                level[i] = 1'b0;
            else
                level[i] = flt[i];
        end
    end
endmodule

/* testbench/test_gpio_pin_config_regs.sv */
`timescale 1ns/1ns
// register and pad checks through the apb port
module test_gpio_pin_config_regs;
    import gpc_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  pin_in, pad_oe_n, rx_enable, pull_down_en, pull_up_en;
    logic [3:0]  low_drive_en, high_drive_en, low_strong, high_strong;
    logic [3:0]  detect, ext_en, ext_val;
    logic        irq;
    logic        got_err;
    logic [31:0] rd;
    int          err_total;
    int          total_checks;
    int          cyc;

    gpc_pin_config uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pad_oe_n(pad_oe_n), .rx_enable(rx_enable),
        .pull_down_en(pull_down_en), .pull_up_en(pull_up_en),
        .low_drive_en(low_drive_en), .high_drive_en(high_drive_en),
        .low_strong(low_strong), .high_strong(high_strong),
        .detect(detect), .irq(irq));

    gpc_pin_model far_side (.clk(pclk), .ext_en(ext_en), .ext_val(ext_val),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .level(pin_in));

    // clock, 100 ns period
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // verdict and end of run
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            test_done;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer: setup, then access until pready at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        got_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // let pad outputs and the pin sampling settle
    task automatic pads;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    // drive table, nibble {low_en, high_en, low_strong, high_strong}
    localparam logic [31:0] DRV_TBL  = 32'hA854FDEC;
    // pull table, two bits {down, up} per code
    localparam logic [7:0]  PULL_TBL = 8'h48;

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        ext_en = 4'h0;
        ext_val = 4'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({16'h0, pad_oe_n, rx_enable, low_drive_en, high_drive_en},
            32'h0000F0FF);
        // reset value, layout and reserved bits of every pin register
        for (int i = 0; i < 4; i++) begin
            rchk(IO12_CONFIG_OFS + 12'(4 * i), 32'h00000002);
            apb(1'b1, IO12_CONFIG_OFS + 12'(4 * i), 32'hFFFFFFFF);
            rchk(IO12_CONFIG_OFS + 12'(4 * i), 32'h0003070F);
            apb(1'b1, IO12_CONFIG_OFS + 12'(4 * i), 32'h00000000);
            rchk(IO12_CONFIG_OFS + 12'(4 * i), 32'h00000000);
        end
        // direction shared with the port direction register
        apb(1'b1, DIR_OFS, 32'h00000005);
        rchk(IO12_CONFIG_OFS, 32'h00000001);
        rchk(IO13_CONFIG_OFS, 32'h00000000);
        apb(1'b1, IO15_CONFIG_OFS, 32'h00000001);
        rchk(DIR_OFS, 32'h0000000D);
        pads;
        chk({28'h0, pad_oe_n}, 32'h00000002);
        // input buffer disconnect on pin 13
        apb(1'b1, IO13_CONFIG_OFS, 32'h00000002);
        pads;
        chk({28'h0, rx_enable}, 32'h0000000D);
        // every drive code on pin 13
        for (int d = 0; d < 8; d++) begin
            apb(1'b1, IO13_CONFIG_OFS, {21'h0, 3'(d), 8'h00});
            pads;
            chk({28'h0, low_drive_en[1], high_drive_en[1], low_strong[1],
                 high_strong[1]}, {28'h0, DRV_TBL[4*d +: 4]});
        end
        chk({24'h0, low_drive_en, high_drive_en},
            32'h000000FD);
        // every pull code on pin 14
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, IO14_CONFIG_OFS, {28'h0, 2'(p), 2'b00});
            pads;
            chk({30'h0, pull_down_en[2], pull_up_en[2]},
                {30'h0, PULL_TBL[2*p +: 2]});
        end
        // sense high on pin 12, unmasked event, sticky status
        @(posedge pclk);
        ext_en <= 4'h1;
        ext_val <= 4'h1;
        apb(1'b1, EVT_MASK_OFS, 32'h00000001);
        apb(1'b1, IO12_CONFIG_OFS, 32'h00020000);
        pads;
        chk({30'h0, detect[0], irq}, 32'h3);
        rchk(EVT_STATUS_OFS, 32'h00000001);
        apb(1'b1, EVT_STATUS_OFS, 32'h00000001);
        rchk(EVT_STATUS_OFS, 32'h00000000);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, IO12_CONFIG_OFS, 32'h00030000);
        pads;
        chk({31'h0, detect[0]}, 32'h0);
        // sense low on pin 13 held low by its pull-down, event masked
        apb(1'b1, IO13_CONFIG_OFS, 32'h00030004);
        pads;
        chk({31'h0, detect[1]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rchk(EVT_STATUS_OFS, 32'h00000002);
        apb(1'b1, EVT_MASK_OFS, 32'h00000003);
        pads;
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, IO13_CONFIG_OFS, 32'h00010004);
        pads;
        chk({31'h0, detect[1]}, 32'h0);
        // pin level register, then sense high on pin 15
        @(posedge pclk);
        ext_en <= 4'hF;
        ext_val <= 4'h9;
        rchk(PIN_LEVEL_OFS, 32'h00000009);
        apb(1'b1, IO15_CONFIG_OFS, 32'h00020000);
        pads;
        chk({28'h0, detect}, 32'h00000008);
        // unmapped address is refused and changes nothing
        apb(1'b1, 12'h760, 32'hFFFFFFFF);
        chk({31'h0, got_err}, 32'h1);
        rchk(12'h760, 32'h00000000);
        rchk(IO15_CONFIG_OFS, 32'h00020000);
        test_done;
    end
endmodule
